// *** sacs_pkg.sv ***
// constants and types shared by the converter sequencer, the analog model and the bench
// assumes a single 10 MHz clock with synchronous reset
package sacs_pkg;
    localparam int                RES_W            = 12;
    localparam int                NPIN             = 8;
    localparam int                NCH              = 9;
    localparam int                CH_W             = 4;
    localparam logic [CH_W-1:0]   TEMP_CH          = 4'h8;
    localparam int                SAMP_W           = 4;
    localparam int                TGT_W            = SAMP_W + 2;
    localparam logic [TGT_W-1:0]  SAMP_MIN         = 6'h06;
    localparam int                CONV_MIN_CLKS    = 18;
    localparam int                CLK_KHZ          = 10000;
    localparam int                CONV_CLK_MAX_KHZ = 14500;
    localparam int                DIV_W            = 8;
    localparam logic [DIV_W-1:0]  DIV_MIN          =
        DIV_W'((CLK_KHZ + CONV_CLK_MAX_KHZ - 1) / CONV_CLK_MAX_KHZ);
    localparam logic [RES_W-1:0]  RES_MSB          = 12'h800;
    localparam logic [RES_W-1:0]  RES_RST          = 12'h000;
    localparam logic [3:0]        BIT_TOP          = 4'hb;
    localparam int                TCNT_W           = 8;

    // ref_int is the nominal 1.024 V internal reference
    typedef enum logic [1:0] {REF_VDD, REF_VDD_HALF, REF_INT, REF_EXT} sacs_ref_t;
    typedef enum logic [1:0] {ST_IDLE, ST_SAMP, ST_CONV} sacs_state_t;
endpackage : sacs_pkg

// *** sacs_mem.sv ***
// per-channel result store with registered read data
// assumes writes and reads share the block clock and clock enable
`timescale 1ns/1ps
module sacs_mem #(
    parameter int DW    = 12,
    parameter int DEPTH = 9,
    parameter int AW    = 4
) (
    input  logic          clk,
    input  logic          rst,
    input  logic          ce,
    input  logic          we,
    input  logic [AW-1:0] waddr,
    input  logic [DW-1:0] wdata,
    input  logic [AW-1:0] raddr,
    output logic [DW-1:0] rd_data_ff
);
    logic [DW-1:0] mem [DEPTH];

    always_ff @(posedge clk) begin
        if (ce && we) begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rd_data_ff <= '0;
        end else if (ce) begin
            rd_data_ff <= (raddr < AW'(DEPTH)) ? mem[raddr] : '0;
        end
    end
endmodule : sacs_mem

// *** sacs_seq.sv ***
// successive-approximation converter control with channel sequencer
// assumes the analog comparator output is synchronous to clk
`timescale 1ns/1ps
module sacs_seq
    import sacs_pkg::*;
(
    input  logic                     clk,
    input  logic                     rst,
    input  logic                     ce,
    input  logic                     power_active,
    input  logic                     start,
    input  logic                     cont_mode,
    input  logic                     fw_mode,
    input  logic [CH_W-1:0]          fw_ch,
    input  logic [NPIN-1:0]          ch_en,
    input  logic                     temp_en,
    input  sacs_ref_t                ref_sel,
    input  logic [DIV_W-1:0]         clk_div,
    input  logic [NCH*SAMP_W-1:0]    samp_time,
    input  logic [RES_W-1:0]         lim_lo,
    input  logic [RES_W-1:0]         lim_hi,
    input  logic                     cmp_hi,
    input  logic                     rd_en,
    input  logic [CH_W-1:0]          rd_ch,
    input  logic [NCH-1:0]           oor_clr,
    input  logic                     done_clr,
    output logic [CH_W-1:0]          mux_sel_ff,
    output logic                     sample_ff,
    output logic [RES_W-1:0]         dac_code_ff,
    output sacs_ref_t                ref_ff,
    output logic                     busy_ff,
    output logic [NCH-1:0]           res_valid_ff,
    output logic [NCH-1:0]           oor_ff,
    output logic                     oor_irq_ff,
    output logic                     scan_done_ff,
    output logic [RES_W-1:0]         rd_data_ff
);
    sacs_state_t       state_ff;
    logic [DIV_W-1:0]  div_cnt_ff;
    logic [TGT_W-1:0]  samp_cnt_ff;
    logic [3:0]        bit_ff;
    logic [NCH-1:0]    en_ff;
    logic              fw_mode_ff;
    logic [TCNT_W-1:0] tick_cnt_ff;
    logic              tick;
    logic [DIV_W-1:0]  div_eff;
    logic [NCH-1:0]    en_now;
    logic              fw_ok;
    logic [CH_W:0]     first_sel;
    logic [CH_W:0]     adv_sel;
    logic              start_ok;
    logic [CH_W-1:0]   start_ch;
    logic              samp_end;
    logic              conv_last;
    logic              scan_end;
    logic              go_on;
    logic [CH_W-1:0]   next_sel;
    logic [RES_W-1:0]  nxt_code;
    logic              in_range;
    logic [NCH-1:0]    nxt_oor;
    logic [NCH-1:0]    nxt_valid;
    logic              nxt_done;

    // {wrap, index}: next enabled channel above cur, or lowest enabled on wrap
    function automatic logic [CH_W:0] next_ch(logic [NCH-1:0] en, logic [CH_W-1:0] cur,
                                             logic first);
        logic [CH_W:0]   r;
        logic            hit;
        logic [CH_W-1:0] low;
        r   = '0;
        hit = 1'b0;
        low = '0;
        for (int j = NCH - 1; j >= 0; j--) begin
            if (en[j]) begin
                low = CH_W'(j);
                if (first || CH_W'(j) > cur) begin
                    r   = {1'b0, CH_W'(j)};
                    hit = 1'b1;
                end
            end
        end
        if (!hit) begin
            r = {1'b1, low};
        end
        return r;
    endfunction : next_ch

    function automatic logic [TGT_W-1:0] samp_len(logic [NCH*SAMP_W-1:0] st,
                                                 logic [CH_W-1:0] ch);
        return SAMP_MIN + TGT_W'(st[ch*SAMP_W +: SAMP_W]);
    endfunction : samp_len

    always_comb begin
        div_eff   = (clk_div < DIV_MIN) ? DIV_MIN : clk_div;
        tick      = ce && (div_cnt_ff == '0);
        en_now    = {temp_en, ch_en};
        fw_ok     = fw_ch < CH_W'(NCH);
        first_sel = next_ch(en_now, '0, 1'b1);
        adv_sel   = next_ch(en_ff, mux_sel_ff, 1'b0);
        start_ok  = ce && state_ff == ST_IDLE && start && power_active
                    && (fw_mode ? fw_ok : |en_now);
        start_ch  = fw_mode ? fw_ch : first_sel[CH_W-1:0];
        samp_end  = tick && state_ff == ST_SAMP
                    && samp_cnt_ff == samp_len(samp_time, mux_sel_ff) - 1'b1;
        conv_last = tick && state_ff == ST_CONV && bit_ff == 4'h0;
        scan_end  = conv_last && (fw_mode_ff || adv_sel[CH_W]);
        go_on     = conv_last && power_active
                    && (!scan_end || (cont_mode && (fw_mode_ff ? fw_ok : |en_now)));
        next_sel  = fw_mode_ff ? fw_ch
                    : (adv_sel[CH_W] ? first_sel[CH_W-1:0] : adv_sel[CH_W-1:0]);
        nxt_code  = dac_code_ff;
        if (!cmp_hi) begin
            nxt_code[bit_ff] = 1'b0;
        end
        if (bit_ff != 4'h0) begin
            nxt_code[bit_ff - 4'h1] = 1'b1;
        end
        in_range  = nxt_code >= lim_lo && nxt_code <= lim_hi;
        nxt_oor   = oor_ff & ~oor_clr;
        if (conv_last && !in_range) begin
            nxt_oor[mux_sel_ff] = 1'b1;
        end
        nxt_valid = res_valid_ff;
        if (rd_en && rd_ch < CH_W'(NCH)) begin
            nxt_valid[rd_ch] = 1'b0;
        end
        if (conv_last) begin
            nxt_valid[mux_sel_ff] = 1'b1;
        end
        nxt_done  = (scan_done_ff && !done_clr) || scan_end;
    end

    // conversion clock: one tick every div_eff system cycles
    always_ff @(posedge clk) begin
        if (rst) begin
            div_cnt_ff <= '0;
        end else if (ce) begin
            if (state_ff == ST_IDLE) begin
                div_cnt_ff <= '0;
            end else if (div_cnt_ff == '0) begin
                div_cnt_ff <= div_eff - 8'h01;
            end else begin
                div_cnt_ff <= div_cnt_ff - 8'h01;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_ff    <= ST_IDLE;
            busy_ff     <= 1'b0;
            sample_ff   <= 1'b0;
            mux_sel_ff  <= '0;
            samp_cnt_ff <= '0;
            en_ff       <= '0;
            fw_mode_ff  <= 1'b0;
            ref_ff      <= REF_VDD;
        end else if (ce) begin
            unique case (state_ff)
                ST_IDLE: begin
                    ref_ff <= ref_sel;
                    if (start_ok) begin
                        state_ff    <= ST_SAMP;
                        busy_ff     <= 1'b1;
                        sample_ff   <= 1'b1;
                        mux_sel_ff  <= start_ch;
                        samp_cnt_ff <= '0;
                        en_ff       <= en_now;
                        fw_mode_ff  <= fw_mode;
                    end
                end
                ST_SAMP: begin
                    if (samp_end) begin
                        state_ff  <= ST_CONV;
                        sample_ff <= 1'b0;
                    end else if (tick) begin
                        samp_cnt_ff <= samp_cnt_ff + 6'h01;
                    end
                end
                ST_CONV: begin
                    if (go_on) begin
                        // next acquisition starts on the cycle after the last bit
                        state_ff    <= ST_SAMP;
                        sample_ff   <= 1'b1;
                        samp_cnt_ff <= '0;
                        mux_sel_ff  <= next_sel;
                        if (scan_end) begin
                            en_ff <= en_now;
                        end
                    end else if (conv_last) begin
                        state_ff <= ST_IDLE;
                        busy_ff  <= 1'b0;
                    end
                end
            endcase
            if (!power_active) begin
                state_ff  <= ST_IDLE;
                busy_ff   <= 1'b0;
                sample_ff <= 1'b0;
            end
        end
    end

    // successive approximation, one bit per conversion tick
    always_ff @(posedge clk) begin
        if (rst) begin
            bit_ff      <= 4'h0;
            dac_code_ff <= RES_RST;
        end else if (samp_end) begin
            bit_ff      <= BIT_TOP;
            dac_code_ff <= RES_MSB;
        end else if (tick && state_ff == ST_CONV) begin
            bit_ff      <= bit_ff - 4'h1;
            dac_code_ff <= nxt_code;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            res_valid_ff <= '0;
            oor_ff       <= '0;
            oor_irq_ff   <= 1'b0;
            scan_done_ff <= 1'b0;
        end else if (ce) begin
            res_valid_ff <= nxt_valid;
            oor_ff       <= nxt_oor;
            oor_irq_ff   <= |nxt_oor;
            scan_done_ff <= nxt_done;
        end
    end

    // conversion ticks since the current acquisition began
    always_ff @(posedge clk) begin
        if (rst) begin
            tick_cnt_ff <= '0;
        end else if (start_ok || go_on) begin
            tick_cnt_ff <= '0;
        end else if (tick && state_ff != ST_IDLE) begin
            tick_cnt_ff <= tick_cnt_ff + 8'h01;
        end
    end

    sacs_mem #(
        .DW    (RES_W),
        .DEPTH (NCH),
        .AW    (CH_W)
    ) u_mem (
        .clk        (clk),
        .rst        (rst),
        .ce         (ce),
        .we         (conv_last),
        .waddr      (mux_sel_ff),
        .wdata      (nxt_code),
        .raddr      (rd_ch),
        .rd_data_ff (rd_data_ff)
    );

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_conv_min_len: assert property (
        conv_last |-> tick_cnt_ff + 8'h01 >= 8'(CONV_MIN_CLKS))
        else $error("conversion shorter than minimum clocks");
    a_ref_load: assert property (
        ce && state_ff == ST_IDLE |=> ref_ff == $past(ref_sel))
        else $error("reference not taken while idle");
    a_samp_window: assert property (
        samp_end |-> tick_cnt_ff + 8'h01 == 8'(samp_len(samp_time, mux_sel_ff)))
        else $error("acquisition length differs from channel setting");
    a_auto_enabled: assert property (
        state_ff == ST_SAMP && !fw_mode_ff |-> en_ff[mux_sel_ff])
        else $error("auto scan on a disabled channel");
    a_gapless_next: assert property (
        go_on |=> sample_ff && state_ff == ST_SAMP)
        else $error("idle gap between channels");
    a_fw_pick: assert property (
        go_on && fw_mode_ff |=> mux_sel_ff == $past(fw_ch))
        else $error("firmware channel not applied");
    a_result_valid: assert property (
        conv_last |=> res_valid_ff[$past(mux_sel_ff)])
        else $error("result buffer flag not set");
    a_oor_flag: assert property (
        conv_last && !in_range |=> oor_ff[$past(mux_sel_ff)] && oor_irq_ff)
        else $error("out-of-range not flagged at once");
    a_temp_conv: assert property (
        start_ok && fw_mode && fw_ch == TEMP_CH |=> mux_sel_ff == TEMP_CH && sample_ff)
        else $error("temperature channel not acquired");
    a_power_gate: assert property (
        ce && !power_active |=> state_ff == ST_IDLE && !sample_ff)
        else $error("conversion outside active power");
    a_oor_sticky: assert property (
        ce && oor_clr == '0 |=> (oor_ff & $past(oor_ff)) == $past(oor_ff))
        else $error("out-of-range flag dropped without clear");
    a_scan_stop: assert property (
        scan_end && !go_on |=> state_ff == ST_IDLE && scan_done_ff)
        else $error("scan end not handled");

    c_scan_wrap: cover property (scan_end && go_on);
    c_oor_hit:   cover property (conv_last && !in_range);
    c_temp_done: cover property (conv_last && mux_sel_ff == TEMP_CH);
endmodule : sacs_seq

// *** sacs_analog_model.sv ***
// analog side model: port 2 pin voltages, temperature sensor and comparator
// assumes mux_sel, sample and dac_code come from the sequencer on clk
`timescale 1ns/1ps
module sacs_analog_model
    import sacs_pkg::*;
(
    input  logic                 clk,
    input  logic [NCH*RES_W-1:0] vin,
    input  logic [CH_W-1:0]      mux_sel,
    input  logic                 sample,
    input  logic [RES_W-1:0]     dac_code,
    output logic                 cmp_hi
);
    logic [RES_W-1:0] level;
    logic             junk_ff = 1'b0;

    // ch 0..7 are the port 2 pins, ch 8 the temperature sensor
    assign level = (mux_sel < CH_W'(NCH)) ? vin[int'(mux_sel)*RES_W +: RES_W]
                                         : ~dac_code;
    always_ff @(posedge clk) begin
        junk_ff <= ~junk_ff;
    end
    // no decision while sampling: a changing pattern, not a held level
    assign cmp_hi = sample ? junk_ff : (level >= dac_code);
endmodule : sacs_analog_model

// *** tb.sv ***
// self-checking bench for the converter sequencer
// assumes the analog model as comparator and a 10 MHz clock
`timescale 1ns/1ps
module tb
    import sacs_pkg::*;
;
    logic                 clk = 1'b0;
    logic                 rst, ce, power_active, start, cont_mode, fw_mode, temp_en;
    logic                 cmp_hi, rd_en, done_clr, sample_ff, busy_ff;
    logic                 oor_irq_ff, scan_done_ff;
    logic [CH_W-1:0]      fw_ch, rd_ch, mux_sel_ff;
    logic [NPIN-1:0]      ch_en;
    sacs_ref_t            ref_sel, ref_ff;
    logic [DIV_W-1:0]     clk_div;
    logic [NCH*SAMP_W-1:0] samp_time;
    logic [RES_W-1:0]     lim_lo, lim_hi, dac_code_ff, rd_data_ff;
    logic [NCH-1:0]       oor_clr, res_valid_ff, oor_ff;
    logic [NCH*RES_W-1:0] vin;
    int                   num_errors = 0;
    int                   num_checks = 0;
    int                   cycles = 0;

    always #50 clk = ~clk;

    sacs_seq u_dut (.clk(clk), .rst(rst), .ce(ce), .power_active(power_active),
        .start(start), .cont_mode(cont_mode), .fw_mode(fw_mode), .fw_ch(fw_ch),
        .ch_en(ch_en), .temp_en(temp_en), .ref_sel(ref_sel), .clk_div(clk_div),
        .samp_time(samp_time), .lim_lo(lim_lo), .lim_hi(lim_hi), .cmp_hi(cmp_hi),
        .rd_en(rd_en), .rd_ch(rd_ch), .oor_clr(oor_clr), .done_clr(done_clr),
        .mux_sel_ff(mux_sel_ff), .sample_ff(sample_ff), .dac_code_ff(dac_code_ff),
        .ref_ff(ref_ff), .busy_ff(busy_ff), .res_valid_ff(res_valid_ff),
        .oor_ff(oor_ff), .oor_irq_ff(oor_irq_ff), .scan_done_ff(scan_done_ff),
        .rd_data_ff(rd_data_ff));

    sacs_analog_model u_afe (.clk(clk), .vin(vin), .mux_sel(mux_sel_ff),
        .sample(sample_ff), .dac_code(dac_code_ff), .cmp_hi(cmp_hi));

    task automatic complete_run();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : complete_run

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            complete_run();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask : tick

    // one idle edge first so a strobe dropped by the previous task is seen low
    task automatic go();
        tick(1);
        start = 1'b1;
        tick(1);
        start = 1'b0;
    endtask : go

    task automatic wait_idle();
        int i;
        i = 0;
        while (busy_ff !== 1'b0 && i < 3000) begin
            tick(1);
            i++;
        end
    endtask : wait_idle

    // reads a result and clears its new-result flag
    task automatic rd(input logic [CH_W-1:0] ch, input logic [RES_W-1:0] exp);
        rd_ch = ch;
        rd_en = 1'b1;
        tick(1);
        chk(rd_data_ff, exp);
        rd_en = 1'b0;
        tick(1);
    endtask : rd

    task automatic t_single();
        int n;
        int s;
        ch_en = 8'h01;
        samp_time[3:0] = 4'h3;
        vin[11:0] = 12'h5a3;
        go();
        n = 0;
        s = 0;
        while (busy_ff === 1'b1 && n < 3000) begin
            n++;
            if (sample_ff === 1'b1) s++;
            tick(1);
        end
        chk(s, 9);
        chk(n, 21);
        chk(dac_code_ff, 12'h5a3);
        chk({res_valid_ff[0], scan_done_ff}, 2'h3);
        rd(4'h0, 12'h5a3);
        done_clr = 1'b1;
        tick(1);
        done_clr = 1'b0;
        chk(scan_done_ff, 1'b0);
        $display("test single done");
    endtask : t_single

    task automatic t_scan();
        int order[3] = '{1, 3, 8};
        int samp[3] = '{2, 5, 0};
        int n;
        int s;
        int k;
        lim_lo = 12'h100;
        lim_hi = 12'h700;
        vin[12 +: 12] = 12'h0ff;
        vin[36 +: 12] = 12'h700;
        vin[96 +: 12] = 12'h100;
        samp_time = {4'h0, 16'h0, 4'h5, 4'h0, 4'h2, 4'h0};
        ch_en = 8'h0a;
        temp_en = 1'b1;
        go();
        n = 0;
        s = 0;
        k = 0;
        while (busy_ff === 1'b1 && n < 3000) begin
            if (sample_ff === 1'b1) begin
                if (s == 0) begin
                    chk(mux_sel_ff, order[k]);
                    if (k == 1) chk({oor_irq_ff, scan_done_ff}, 2'h2);
                end
                s++;
            end else if (s != 0) begin
                chk(s, 6 + samp[k]);
                s = 0;
                k++;
            end
            n++;
            tick(1);
        end
        chk(k, 3);
        chk({res_valid_ff, scan_done_ff}, {9'h10a, 1'b1});
        chk(oor_ff, 9'h002);
        rd(4'h1, 12'h0ff);
        rd(4'h3, 12'h700);
        rd(4'h8, 12'h100);
        chk({res_valid_ff, oor_irq_ff}, {9'h000, 1'b1});
        oor_clr = 9'h002;
        done_clr = 1'b1;
        tick(1);
        oor_clr = 9'h000;
        done_clr = 1'b0;
        chk({oor_ff, oor_irq_ff}, 10'h000);
        chk(scan_done_ff, 1'b0);
        temp_en = 1'b0;
        $display("test scan done");
    endtask : t_scan

    task automatic t_cont();
        int n;
        int k;
        int last;
        logic prev;
        samp_time = '0;
        ch_en = 8'h05;
        cont_mode = 1'b1;
        go();
        n = 0;
        k = 0;
        last = 0;
        prev = 1'b0;
        while (k < 3 && n < 200) begin
            if (sample_ff === 1'b1 && prev === 1'b0) begin
                chk(mux_sel_ff, (k == 1) ? 2 : 0);
                if (k > 0) chk(n - last, 18);
                if (k > 0) chk(scan_done_ff, k == 2);
                last = n;
                k++;
            end
            prev = sample_ff;
            n++;
            tick(1);
        end
        cont_mode = 1'b0;
        wait_idle();
        chk({busy_ff, scan_done_ff}, 2'h1);
        rd(4'h0, 12'h5a3);
        rd(4'h2, 12'h000);
        $display("test continuous done");
    endtask : t_cont

    task automatic t_fw();
        fw_mode = 1'b1;
        fw_ch = 4'h5;
        ch_en = 8'h00;
        vin[60 +: 12] = 12'h3c7;
        go();
        chk({busy_ff, mux_sel_ff}, {1'b1, 4'h5});
        wait_idle();
        rd(4'h5, 12'h3c7);
        fw_ch = 4'h8;
        cont_mode = 1'b1;
        go();
        chk({sample_ff, mux_sel_ff}, {1'b1, 4'h8});
        fw_ch = 4'h5;
        tick(18);
        chk({sample_ff, mux_sel_ff}, {1'b1, 4'h5});
        cont_mode = 1'b0;
        wait_idle();
        rd(4'h8, 12'h100);
        rd(4'h5, 12'h3c7);
        fw_ch = 4'h9;
        go();
        chk(busy_ff, 1'b0);
        fw_mode = 1'b0;
        $display("test firmware done");
    endtask : t_fw

    task automatic t_power();
        ch_en = 8'h01;
        go();
        tick(5);
        power_active = 1'b0;
        tick(2);
        chk({busy_ff, res_valid_ff}, 10'h000);
        go();
        chk(busy_ff, 1'b0);
        power_active = 1'b1;
        $display("test power done");
    endtask : t_power

    // divide by two, with ce held low for four edges right after the start
    task automatic t_div();
        int n;
        clk_div = 8'h02;
        ch_en = 8'h01;
        go();
        ce = 1'b0;
        tick(4);
        ce = 1'b1;
        n = 4;
        while (busy_ff === 1'b1 && n < 3000) begin
            n++;
            tick(1);
        end
        chk(n, 39);
        rd(4'h0, 12'h5a3);
        clk_div = 8'h01;
        $display("test divider done");
    endtask : t_div

    task automatic t_ref();
        for (int r = 0; r < 4; r++) begin
            ref_sel = sacs_ref_t'(r);
            tick(2);
            chk(ref_ff, r);
        end
        $display("test reference done");
    endtask : t_ref

    initial begin
        rst = 1'b1;
        ce = 1'b1;
        power_active = 1'b1;
        {start, cont_mode, fw_mode, temp_en, rd_en, done_clr} = '0;
        fw_ch = 4'h0;
        rd_ch = 4'h0;
        ch_en = 8'h00;
        ref_sel = REF_VDD;
        clk_div = 8'h01;
        samp_time = '0;
        lim_lo = 12'h000;
        lim_hi = 12'hfff;
        oor_clr = 9'h000;
        vin = '0;
        tick(6);
        rst = 1'b0;
        chk({busy_ff, scan_done_ff, oor_ff, res_valid_ff}, 20'h0);
        t_single();
        t_scan();
        t_cont();
        t_fw();
        t_power();
        t_div();
        t_ref();
        complete_run();
    end
endmodule : tb
